//--- verilog/hah_pkg.sv
// constants and carrier types for the host access handshake block
// assumes a 25 MHz core clock; link pins are sampled, not used as clocks
// How it works
// - host low wake line starts preparation
// - ready asserted with configured polarity
// - after ready, device sets halt register
// - halt ends itself after 2048 ms
// - while halted, serve reads and writes
// - transfer during notify pulse flags contention
// - select pulse without clocks flags clock fault
// - first transfer after fault only clears
// - on clear: resume, ready off, spi off
// - enable spi as switch wait or notify pulse starts
// - power switch on, wait 200 ms first
// - pulse polarity and length are configurable
// - halt right after notify pulse ends
// - acknowledged flags cleared after session ends
// - halt is nonzero, release is zero
// - after release of a device session, run host commands
package hah_pkg;
	localparam int unsigned CLK_HZ = 25000000; // core clock rate
	localparam int unsigned HALT_TIMEOUT_MS = 2048; // halt limit
	localparam int unsigned PS_WAIT_MS = 200; // power switch settle time
	localparam int unsigned PULSE_SHORT_US = 100; // short notify pulse
	localparam int unsigned PULSE_LONG_US = 1000; // long notify pulse
	localparam int unsigned HALT_CYC = HALT_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned PS_CYC = PS_WAIT_MS * (CLK_HZ / 1000);
	localparam int unsigned PULSE_SHORT_CYC = PULSE_SHORT_US * (CLK_HZ / 1000000);
	localparam int unsigned PULSE_LONG_CYC = PULSE_LONG_US * (CLK_HZ / 1000000);
	localparam int unsigned WORD_BITS = 16; // one spi transfer
	localparam int unsigned CNT_W = 32; // timer width
	localparam logic [7:0] HALT_SET_VAL = 8'h01; // nonzero halt marker
	localparam logic [7:0] HALT_CLR_VAL = 8'h00; // released value

	// configuration bits, driven by the device firmware side
	typedef struct packed {
		logic ready_int_polarity; // 1: active high ready/notify
		logic int_pulse_duration; // 1: long pulse
		logic power_switch_enable; // use power switch output
	} hah_cfg_t;

	// spi status seen by the host
	typedef struct packed {
		logic clock_fault; // select without clocks
		logic contention; // transfer during notify pulse
	} hah_stat_t;

	// handshake sequencer states
	typedef enum logic [3:0] {
		ST_IDLE, ST_PREP, ST_READY, ST_PSWAIT, ST_PULSE,
		ST_HALT, ST_RELEASE, ST_SPIOFF
	} hah_state_t;
endpackage : hah_pkg

//--- verilog/hah_link_mon.sv
// link monitor: samples the host select and serial clock pins
// assumes pins are asynchronous to mclk_in; two flops before use
`timescale 1ns/1ps
`default_nettype none
module hah_link_mon (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic cs_n_in,
	input wire logic sclk_in,
	output logic cs_fall_out,
	output logic cs_rise_out,
	output logic sclk_rise_out,
	output logic cs_low_out
);
	import hah_pkg::*;
	logic [1:0] cs_sync_q; // select synchroniser
	logic [1:0] sck_sync_q; // clock synchroniser
	logic cs_prev_q; // last synced select
	logic sck_prev_q; // last synced clock

	// two stage synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cs_sync_q <= 2'h3;
			sck_sync_q <= 2'h0;
		end else begin
			cs_sync_q <= {cs_sync_q[0], cs_n_in};
			sck_sync_q <= {sck_sync_q[0], sclk_in};
		end
	end

	// history for edge detection on the settled copies
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cs_prev_q <= 1'b1;
			sck_prev_q <= 1'b0;
		end else begin
			cs_prev_q <= cs_sync_q[1];
			sck_prev_q <= sck_sync_q[1];
		end
	end

	assign cs_fall_out = cs_prev_q & ~cs_sync_q[1];
	assign cs_rise_out = ~cs_prev_q & cs_sync_q[1];
	assign sclk_rise_out = ~sck_prev_q & sck_sync_q[1] & ~cs_sync_q[1];
	assign cs_low_out = ~cs_sync_q[1];
endmodule : hah_link_mon
`default_nettype wire

//--- verilog/hah_handshake.sv
// host access handshake: wake/ready, notify pulse, halt and spi faults
// assumes firmware gives events, config and host halt writes as ports
`timescale 1ns/1ps
`default_nettype none
module hah_handshake #(
	parameter int unsigned HALT_CYCLES = hah_pkg::HALT_CYC,
	parameter int unsigned PS_CYCLES = hah_pkg::PS_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic cs_n_in, // host chip select / wake line
	input wire logic sclk_in, // host serial clock
	input wire hah_pkg::hah_cfg_t cfg_in, // static configuration
	input wire logic event_in, // pulse: event needs host attention
	input wire logic host_halt_wr_in, // pulse: host writes halt reg
	input wire logic [7:0] host_halt_data_in, // data of that write
	input wire logic host_ack_wr_in, // pulse: host sets flag_acknowledge
	output logic ready_int_out, // ready/notify pin level
	output logic power_switch_enable_out, // power switch pin
	output logic spi_enable_out, // spi block enable
	output logic [7:0] host_access_halt_out, // halt register value
	output logic halted_out, // core stopped for host access
	output logic mem_access_en_out, // spi may touch memory
	output hah_pkg::hah_stat_t spi_status_out, // spi fault status
	output logic cmd_valid_out, // accept spi command this word
	output logic run_cmds_out, // pulse: execute host commands
	output logic flag_clear_out // pulse: clear acknowledged flags
);
	import hah_pkg::*;

	logic cs_fall, cs_rise, sclk_rise, cs_low;
	hah_state_t st_q; // sequencer state
	logic [CNT_W-1:0] tmr_q; // shared wait / timeout timer
	logic dev_init_q; // current episode started by the device
	logic [7:0] halt_q; // host_access_halt register
	logic [4:0] bits_q; // clocks seen in the current select
	logic clk_fault_q; // clock fault status bit
	logic discard_q; // next word only clears the fault
	logic contend_q; // contention status bit
	logic ack_q; // host acknowledged flags this session
	logic notify_act; // notify pulse currently on the pin
	logic rdy_act; // ready level asserted (logical)
	logic word_done; // one 16 bit word finished
	logic pulse_end; // last cycle of the notify pulse
	logic clk_seen_q; // a clock edge came in the current select

	hah_link_mon u_mon (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.cs_n_in(cs_n_in),
		.sclk_in(sclk_in),
		.cs_fall_out(cs_fall),
		.cs_rise_out(cs_rise),
		.sclk_rise_out(sclk_rise),
		.cs_low_out(cs_low)
	);

	// pulse length from the duration bit
	function automatic logic [CNT_W-1:0] pulse_len(input logic long_sel);
		pulse_len = long_sel ? CNT_W'(PULSE_LONG_CYC) : CNT_W'(PULSE_SHORT_CYC);
	endfunction : pulse_len

	assign notify_act = (st_q == ST_PULSE);
	assign rdy_act = (st_q == ST_READY) | (st_q == ST_HALT & ~dev_init_q);
	assign word_done = sclk_rise & (bits_q == 5'(WORD_BITS - 1));
	// shared by the sequencer and the halt register so both agree
	assign pulse_end = notify_act
	    & (tmr_q >= pulse_len(cfg_in.int_pulse_duration) - 1);

	// sequencer; the timer is shared since only one wait runs at a time
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= ST_IDLE;
			tmr_q <= '0;
			dev_init_q <= 1'b0;
		end else begin
			// free runs by default; each state that starts a wait zeroes it
			tmr_q <= tmr_q + CNT_W'(1);
			unique case (st_q)
				ST_IDLE: begin
					// parked: timer held at zero until a wake or an event
					tmr_q <= '0;
					if (cs_fall) begin
						// host wake takes priority over a device event
						st_q <= ST_PREP;
						dev_init_q <= 1'b0;
					end else if (event_in) begin
						dev_init_q <= 1'b1;
						// spi enabled in the same cycle the wait or pulse starts
						st_q <= cfg_in.power_switch_enable ? ST_PSWAIT : ST_PULSE;
					end
				end
				ST_PREP: st_q <= ST_READY; // one cycle to enable spi
				ST_READY: begin
					st_q <= ST_HALT; // halt written after ready
					tmr_q <= '0; // fresh timeout per episode
				end
				ST_PSWAIT: if (tmr_q >= CNT_W'(PS_CYCLES - 1)) begin
					st_q <= ST_PULSE; // 200 ms settle done
					tmr_q <= '0;
				end
				ST_PULSE: if (pulse_end) begin
					st_q <= ST_HALT; // halt right after pulse
					tmr_q <= '0;
				end
				ST_HALT: begin
					// release on host clear or after the limit
					if ((host_halt_wr_in && host_halt_data_in == HALT_CLR_VAL)
					    || tmr_q >= CNT_W'(HALT_CYCLES - 1)) begin
						st_q <= ST_RELEASE;
					end
				end
				ST_RELEASE: st_q <= ST_SPIOFF; // ready drops here
				ST_SPIOFF: st_q <= ST_IDLE; // spi disabled last
				// unused codes of the state vector fall back to idle
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// halt register: device writes nonzero, host clears to zero
	// a host write of a nonzero value simply keeps the core halted
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			halt_q <= HALT_CLR_VAL;
		end else if ((st_q == ST_READY) || pulse_end) begin
			halt_q <= HALT_SET_VAL;
		end else if (st_q == ST_HALT && host_halt_wr_in) begin
			halt_q <= host_halt_data_in; // host write; zero is a release
		end else if (st_q == ST_RELEASE) begin
			halt_q <= HALT_CLR_VAL; // timeout also clears it
		end
	end

	// clock counter per select; finds the 16 bit word boundary
	// a word boundary wraps the count so back to back words line up
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			bits_q <= '0;
		end else if (cs_fall || cs_rise) begin
			bits_q <= '0;
		end else if (sclk_rise) begin
			bits_q <= word_done ? 5'h0 : bits_q + 5'h1;
		end
	end

	// any clock in this select; a full word leaves bits_q at zero again,
	// so the count alone cannot tell an empty select from a finished one
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			clk_seen_q <= 1'b0;
		end else if (cs_fall) begin
			clk_seen_q <= 1'b0;
		end else if (sclk_rise && cs_low) begin
			clk_seen_q <= 1'b1;
		end
	end

	// clock fault: set wins over the clearing word
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			clk_fault_q <= 1'b0;
			discard_q <= 1'b0;
		end else if (cs_rise && !clk_seen_q) begin
			clk_fault_q <= 1'b1; // select pulsed without clocks
			discard_q <= 1'b1;
		end else if (word_done && discard_q) begin
			clk_fault_q <= 1'b0; // dummy word clears fault
			discard_q <= 1'b0;
		end
	end

	// contention: clocks while notify pulse is on
	// limitation: a clock in the last two pulse cycles may be missed
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			contend_q <= 1'b0;
		end else if (notify_act && sclk_rise) begin
			contend_q <= 1'b1;
		end else if (word_done) begin
			contend_q <= 1'b0; // reported, next word clears it
		end
	end

	// acknowledge held until the session ends
	// an ack outside the halt is ignored; the host cannot reach it then
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_q <= 1'b0;
		end else if (st_q == ST_HALT && host_ack_wr_in) begin
			ack_q <= 1'b1;
		end else if (st_q == ST_SPIOFF) begin
			ack_q <= 1'b0;
		end
	end

	// registered outputs, decoded from the current state, so one cycle late
	// release lasts one cycle, so each pulse lasts one cycle too
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			run_cmds_out <= 1'b0;
			flag_clear_out <= 1'b0;
			power_switch_enable_out <= 1'b0;
		end else begin
			// commands run once the device session is released
			run_cmds_out <= (st_q == ST_RELEASE) & dev_init_q;
			flag_clear_out <= (st_q == ST_RELEASE) & ack_q;
			// power switch held through wait, pulse and halt
			power_switch_enable_out <= cfg_in.power_switch_enable
			    & (st_q == ST_PSWAIT | st_q == ST_PULSE | st_q == ST_HALT)
			    & dev_init_q;
		end
	end

	// pin level follows polarity; idle is the inverse
	assign ready_int_out = (rdy_act | notify_act)
	    ? cfg_in.ready_int_polarity : ~cfg_in.ready_int_polarity;
	// spi on from prep/psw/pulse until after release
	assign spi_enable_out = (st_q != ST_IDLE) & (st_q != ST_SPIOFF);
	assign host_access_halt_out = halt_q;
	assign halted_out = (st_q == ST_HALT);
	assign mem_access_en_out = (st_q == ST_HALT);
	assign cmd_valid_out = mem_access_en_out & ~discard_q;
	assign spi_status_out = '{clock_fault: clk_fault_q, contention: contend_q};
endmodule : hah_handshake
`default_nettype wire

//--- tb/hah_handshake_sva.sv
// checker for the host access handshake ports
// assumes a bind onto hah_handshake, counts handed on from it
`timescale 1ns/1ps
`default_nettype none
module hah_handshake_sva #(
	parameter int unsigned HALT_CYCLES = 200,
	parameter int unsigned PS_CYCLES = 50
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire hah_pkg::hah_cfg_t cfg_in,
	input wire logic host_halt_wr_in,
	input wire logic [7:0] host_halt_data_in,
	input wire logic ready_int_out,
	input wire logic spi_enable_out,
	input wire logic [7:0] host_access_halt_out,
	input wire logic halted_out,
	input wire hah_pkg::hah_stat_t spi_status_out,
	input wire logic cmd_valid_out,
	input wire logic run_cmds_out,
	input wire logic flag_clear_out
);
	import hah_pkg::*;
	logic act; // line at its active level
	logic seen_q; // a clock edge came during this select
	logic [31:0] on_q; // active cycles, held until spi is off
	logic [31:0] hold_q; // cycles spent halted
	assign act = ready_int_out == cfg_in.ready_int_polarity;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// clock seen since select fell; pins are slow, so sampling is enough
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			seen_q <= 1'b0;
		else if ($fell(cs_n_in))
			seen_q <= 1'b0;
		else if ($rose(sclk_in))
			seen_q <= 1'b1;
	end
	// pulse length is kept through the halt so it can be judged at its end
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			on_q <= '0;
			hold_q <= '0;
		end else begin
			on_q <= act ? on_q + 1 : (spi_enable_out ? on_q : '0);
			hold_q <= halted_out ? hold_q + 1 : '0;
		end
	end
	a_halt_marker: assert property (
		halted_out |-> host_access_halt_out == 8'h01) else $error("halt value");
	a_spi_first: assert property (
		act || halted_out |-> spi_enable_out) else $error("spi off");
	a_wake_ready: assert property (
		$fell(cs_n_in) && !spi_enable_out |-> ##[3:6] act) else $error("no ready");
	a_halt_entry: assert property (
		$rose(halted_out) |-> $past(act)) else $error("halt out of turn");
	a_release_order: assert property (
		halted_out && host_halt_wr_in && host_halt_data_in == 8'h00 |=> !act
		&& !halted_out && spi_enable_out && host_access_halt_out == 8'h00
		##1 !spi_enable_out) else $error("release order");
	a_halt_limit: assert property (
		hold_q <= HALT_CYCLES + 1) else $error("halt too long");
	a_pulse_len: assert property (
		$rose(halted_out) && !act |-> on_q == (cfg_in.int_pulse_duration ?
		PULSE_LONG_CYC : PULSE_SHORT_CYC)) else $error("pulse length");
	a_clock_fault: assert property (
		$rose(cs_n_in) && !seen_q |-> ##[1:6] spi_status_out.clock_fault)
		else $error("no clock fault");
	a_dummy_word: assert property (
		spi_status_out.clock_fault |-> !cmd_valid_out) else $error("cmd taken");
	a_bus_clash: assert property (
		act && !halted_out && !cs_n_in && $rose(sclk_in) |-> ##[1:6]
		spi_status_out.contention) else $error("no contention");
	a_after_release: assert property (
		run_cmds_out || flag_clear_out |-> !halted_out && $past(halted_out, 2))
		else $error("early commands");
endmodule : hah_handshake_sva
bind hah_handshake hah_handshake_sva #(.HALT_CYCLES(HALT_CYCLES),
	.PS_CYCLES(PS_CYCLES)) u_sva (
	.mclk_in(mclk_in),
	.rst_in(rst_in),
	.cs_n_in(cs_n_in),
	.sclk_in(sclk_in),
	.cfg_in(cfg_in),
	.host_halt_wr_in(host_halt_wr_in),
	.host_halt_data_in(host_halt_data_in),
	.ready_int_out(ready_int_out),
	.spi_enable_out(spi_enable_out),
	.host_access_halt_out(host_access_halt_out),
	.halted_out(halted_out),
	.spi_status_out(spi_status_out),
	.cmd_valid_out(cmd_valid_out),
	.run_cmds_out(run_cmds_out),
	.flag_clear_out(flag_clear_out)
);
`default_nettype wire

//--- tb/hah_host_model.sv
// host pin model: select/wake line and a 320 ns serial clock
// assumes the bench calls its tasks; the clock stands low between words
`timescale 1ns/1ps
`default_nettype none
module hah_host_model (
	output logic cs_n_out,
	output logic sclk_out
);
	initial begin
		cs_n_out = 1'b1; // not selected
		sclk_out = 1'b0; // clock still outside frames
	end
	// wake request: select low with no clock, as a gpio would do it
	task automatic wake(input int unsigned ns);
		cs_n_out = 1'b0;
		#(ns);
		cs_n_out = 1'b1;
	endtask : wake
	// one whole 16 bit word; the trailing gap lets the core resync
	task automatic word();
		cs_n_out = 1'b0;
		#160;
		repeat (16) begin
			sclk_out = 1'b1;
			#160;
			sclk_out = 1'b0;
			#160;
		end
		cs_n_out = 1'b1;
		#320;
	endtask : word
endmodule : hah_host_model
`default_nettype wire

//--- tb/hah_handshake_tb.sv
// bench for the host access handshake with a host pin model
// assumes shortened halt and switch counts, set at the instance
`timescale 1ns/1ps
`default_nettype none
module hah_handshake_tb;
	import hah_pkg::*;
	logic mclk_in, rst_in, cs_n, sclk, ev, hw, aw, rdy, pse, spi, hlt, mem;
	logic cv, run, fclr, seen;
	logic [7:0] hd, hreg;
	hah_cfg_t cfg;
	hah_stat_t st;
	int err_count, compares, n;
	hah_host_model host (.cs_n_out(cs_n), .sclk_out(sclk));
	hah_handshake #(.HALT_CYCLES(200), .PS_CYCLES(50)) dut (
		.mclk_in(mclk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk),
		.cfg_in(cfg), .event_in(ev), .host_halt_wr_in(hw),
		.host_halt_data_in(hd), .host_ack_wr_in(aw), .ready_int_out(rdy),
		.power_switch_enable_out(pse), .spi_enable_out(spi),
		.host_access_halt_out(hreg), .halted_out(hlt), .mem_access_en_out(mem),
		.spi_status_out(st), .cmd_valid_out(cv), .run_cmds_out(run),
		.flag_clear_out(fclr));
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end
	// case equality, so an unknown never matches
	task automatic chk(input string nm, input logic [7:0] exp, got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// bounded wait on a level of a signal; n holds the cycles taken
	task automatic wait_on(input logic lvl, input bit on_halt);
		n = 0;
		while ((on_halt ? hlt : rdy) !== lvl && n < 40000) begin
			@(negedge mclk_in);
			n++;
		end
		chk("wait level", {7'h0, lvl}, {7'h0, on_halt ? hlt : rdy});
	endtask : wait_on
	// one-cycle pulse of the halt write, the ack, or an event
	task automatic pulse(input int k, input logic [7:0] d);
		@(negedge mclk_in);
		hd = d;
		{ev, aw, hw} = 3'h1 << k;
		@(negedge mclk_in);
		{ev, aw, hw} = 3'h0;
	endtask : pulse
	initial begin
		#3000000;
		err_count++;
		finish_test();
	end
	initial begin
		cfg = 3'h4; // active high line, short pulse, no switch
		{ev, aw, hw, hd, rst_in} = {11'h0, 1'b1};
		repeat (2) @(negedge mclk_in);
		rst_in = 1'b0;
		repeat (2) @(negedge mclk_in);
		host.wake(400);
		wait_on(1'b1, 0);
		@(negedge mclk_in);
		chk("halt reg", 8'h01, hreg);
		repeat (8) @(negedge mclk_in);
		chk("clock fault", 8'h01, {7'h0, st.clock_fault});
		chk("cmd valid", 8'h00, {7'h0, cv});
		host.word();
		chk("cmd after dummy", 8'h01, {7'h0, cv & mem});
		pulse(0, 8'h00);
		chk("release", 8'h01, {hreg[6:0], spi & ~rdy});
		@(negedge mclk_in);
		chk("spi off", 8'h00, {7'h0, spi});
		$display("test host wake done");
		cfg = 3'h0; // active low line, short pulse
		pulse(2, 8'h00);
		chk("spi first", 8'h01, {7'h0, spi});
		wait_on(1'b1, 0);
		chk("short pulse", 8'h01, {7'h0, n > 2490 && n < 2510});
		wait_on(1'b1, 1);
		host.word();
		pulse(1, 8'h00);
		pulse(0, 8'h00);
		seen = 1'b0;
		repeat (4) begin
			seen = seen | (run & fclr);
			@(negedge mclk_in);
		end
		chk("run and clear", 8'h01, {7'h0, seen});
		$display("test notify done");
		cfg = 3'h7; // active high, long pulse, power switch used
		pulse(2, 8'h00);
		wait_on(1'b1, 0);
		chk("switch wait", 8'h01, {7'h0, pse && n > 45 && n < 55});
		wait_on(1'b0, 0);
		chk("long pulse", 8'h01, {7'h0, n > 24990 && n < 25010});
		wait_on(1'b0, 1);
		chk("timeout", 8'h01, {7'h0, n > 195 && n < 206});
		@(negedge mclk_in);
		chk("timeout clears", 8'h00, hreg);
		$display("test switch and timeout done");
		cfg = 3'h4;
		repeat (4) @(negedge mclk_in);
		pulse(2, 8'h00);
		wait_on(1'b1, 0);
		host.word();
		chk("contention", 8'h01, {7'h0, st.contention});
		wait_on(1'b1, 1);
		host.word();
		chk("contention clear", 8'h00, {7'h0, st.contention});
		pulse(0, 8'h00);
		$display("test contention done");
		finish_test();
	end
endmodule : hah_handshake_tb
`default_nettype wire
